// >>> verilog/ocd_regs.svh
`ifndef OCD_REGS_SVH
`define OCD_REGS_SVH
// comparison window length and clock period in ns
`define OCD_WINDOW_NS 10000
`define OCD_CLK_NS 50
`define OCD_WIN_CYC (`OCD_WINDOW_NS / `OCD_CLK_NS)
// consecutive windows needed per delay setting
`define OCD_RUN_SHORT 4'h1
`define OCD_RUN_MED 4'h5
`define OCD_RUN_LONG 4'hA
// strap level codes: open, ground, supply
`define OCD_STRAP_OPEN 2'h0
`define OCD_STRAP_GND 2'h1
`define OCD_STRAP_VS 2'h2
// release margin in microvolts per hysteresis setting
`define OCD_HYS_2MV 16'h07D0
`define OCD_HYS_4MV 16'h0FA0
`define OCD_HYS_8MV 16'h1F40
// noise offset correction in microvolts, short setting only
`define OCD_NOISE_UV 16'h01F4
`endif

// >>> verilog/ocd_pkg.sv
`default_nettype none
package ocd_pkg;
  typedef enum logic [1:0] {OCD_DLY_10, OCD_DLY_50, OCD_DLY_100} ocd_dly_t;
  typedef enum logic {OCD_IDLE, OCD_ALERT} ocd_state_t;
endpackage
`default_nettype wire

// >>> verilog/ocd_core.sv
// Overview of operation
// - a fixed 10 us window runs freely and restarts at once
// - each window end compares the averaged input against the limit
// - short setting: one over-limit verdict drives alert low at once
// - in-range verdict with no alert pending leaves alert high
// - medium setting: alert after five consecutive over-limit windows
// - an in-range verdict before the count clears the counter
// - long setting: alert after ten consecutive over-limit windows
// - delay strap: open 10 us, ground 50 us, supply 100 us
// - window is not aligned to input; latency varies by one window
// - medium adds 40 us, long adds 90 us over single window
// - hysteresis strap: open 2 mV, ground 4 mV, supply 8 mV
// - alert is active low open drain, pulled low while flagged
// - every delay setting releases alert after one in-range window
// - disable resets the counter; counting restarts on enable
`timescale 1ns/1ps
`default_nettype none
`include "ocd_regs.svh"
module ocd_core
  import ocd_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // control
  input wire logic enable,
  input wire logic [1:0] delay_strap,
  input wire logic [1:0] hysteresis_select_strap,
  // sense path, microvolts
  input wire logic [15:0] sense_uv,
  input wire logic [15:0] limit_uv,
  // status
  output logic [15:0] noise_offset_correction,
  output logic [15:0] release_margin_uv,
  output logic window_end,
  output logic over_verdict,
  // alert pin, open drain
  output logic alert_n_o,
  output logic alert_n_oe_n
);
  localparam logic [8:0] WIN_LAST = 9'(`OCD_WIN_CYC - 1);

  logic [8:0] win_cnt_r;
  logic [24:0] acc_r;
  logic [3:0] run_r;
  ocd_state_t state_r;
  logic [15:0] avg_r;
  logic verdict_r;
  logic wend_r;
  logic [15:0] margin_r;
  logic [15:0] noise_r;

  // strap decode
  ocd_dly_t dly;
  wire [3:0] run_need;
  assign dly = (delay_strap == `OCD_STRAP_GND) ? OCD_DLY_50 :
               (delay_strap == `OCD_STRAP_VS) ? OCD_DLY_100 :
               OCD_DLY_10;
  assign run_need = (dly == OCD_DLY_50) ? `OCD_RUN_MED :
                    (dly == OCD_DLY_100) ? `OCD_RUN_LONG :
                    `OCD_RUN_SHORT;
  wire [15:0] margin_sel;
  wire [15:0] noise_sel;
  assign margin_sel =
    (hysteresis_select_strap == `OCD_STRAP_GND) ? `OCD_HYS_4MV :
    (hysteresis_select_strap == `OCD_STRAP_VS) ? `OCD_HYS_8MV :
    `OCD_HYS_2MV;
  assign noise_sel =
    (dly == OCD_DLY_10) ? `OCD_NOISE_UV : 16'h0000;

  // window end and average
  wire win_last = (win_cnt_r == WIN_LAST);
  wire [24:0] acc_sum = acc_r + {9'h000, sense_uv};
  wire [15:0] avg_now = 16'(acc_sum / 25'(`OCD_WIN_CYC));
  // trip above limit plus noise offset; once alerted, release below limit minus margin
  wire [16:0] trip_lvl = {1'b0, limit_uv} + {1'b0, noise_offset_correction};
  wire [16:0] rel_lvl = (limit_uv > release_margin_uv) ?
                        {1'b0, limit_uv - release_margin_uv} : 17'h00000;
  wire over_now = (state_r == OCD_ALERT) ?
                  ({1'b0, avg_now} > rel_lvl) :
                  ({1'b0, avg_now} > trip_lvl);
  wire run_hit = ({1'b0, run_r} + 5'h01) >= {1'b0, run_need};

  // free running window counter, not synced to input
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      win_cnt_r <= 9'h000;
      acc_r <= 25'h0000000;
    end else if (!enable || win_last) begin
      win_cnt_r <= 9'h000;
      acc_r <= 25'h0000000;
    end else begin
      win_cnt_r <= win_cnt_r + 9'h001;
      acc_r <= acc_sum;
    end
  end

  // verdict registers
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      avg_r <= 16'h0000;
      verdict_r <= 1'b0;
      wend_r <= 1'b0;
    end else begin
      wend_r <= enable && win_last;
      if (enable && win_last) begin
        avg_r <= avg_now;
        verdict_r <= over_now;
      end
    end
  end

  // consecutive counter and alert state
  ocd_state_t state_nxt;
  logic [3:0] run_nxt;
  always_comb begin
    state_nxt = state_r;
    run_nxt = run_r;
    if (!enable) begin
      run_nxt = 4'h0;
      state_nxt = OCD_IDLE;
    end else if (win_last) begin
      case (state_r)
        OCD_IDLE: begin
          if (!over_now) begin
            run_nxt = 4'h0;
          end else if (run_hit) begin
            run_nxt = 4'h0;
            state_nxt = OCD_ALERT;
          end else begin
            run_nxt = run_r + 4'h1;
          end
        end
        OCD_ALERT: begin
          if (!over_now) begin
            state_nxt = OCD_IDLE;
          end
        end
        default: state_nxt = OCD_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_r <= OCD_IDLE;
      run_r <= 4'h0;
    end else begin
      state_r <= state_nxt;
      run_r <= run_nxt;
    end
  end

  // outputs
  assign window_end = wend_r;
  assign over_verdict = verdict_r;
  assign alert_n_o = 1'b0;
  assign alert_n_oe_n = (state_r != OCD_ALERT);

  // strap-derived levels held in flops
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      margin_r <= `OCD_HYS_2MV;
      noise_r <= `OCD_NOISE_UV;
    end else begin
      margin_r <= margin_sel;
      noise_r <= noise_sel;
    end
  end
  assign release_margin_uv = margin_r;
  assign noise_offset_correction = noise_r;

  // assertions
  a_alert_on_trip: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    (enable && win_last && state_r == OCD_IDLE && over_now && run_hit)
    |=> !alert_n_oe_n)
    else $error("alert not asserted on trip");
  a_short_trip: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    (enable && win_last && dly == OCD_DLY_10 && state_r == OCD_IDLE &&
    over_now) |=> !alert_n_oe_n)
    else $error("short setting did not trip");
  a_window_period: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    (enable && win_last) |=> !win_last [*8])
    else $error("window restarted too soon");
  a_wend_pulse: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    window_end |=> !window_end)
    else $error("window end pulse too long");
  a_verdict_load: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    (enable && win_last) |=> over_verdict == $past(over_now))
    else $error("verdict not taken at window end");
  a_inrange_clears: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    (enable && win_last && state_r == OCD_IDLE && !over_now)
    |=> run_r == 4'h0 && alert_n_oe_n)
    else $error("counter not cleared");
  a_quiet_no_alert: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    (alert_n_oe_n && !(enable && win_last)) |=> alert_n_oe_n)
    else $error("alert changed between windows");
  a_disable_clear: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    !enable |=> run_r == 4'h0 && alert_n_oe_n)
    else $error("disable did not clear");
  a_run_bound: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    run_r < run_need || $changed(delay_strap))
    else $error("run count past limit");
  a_med_needs: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    ($fell(alert_n_oe_n) && dly == OCD_DLY_50 && $stable(delay_strap))
    |-> $past(run_r) == 4'h4)
    else $error("medium alert without five windows");
  a_long_needs: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    ($fell(alert_n_oe_n) && dly == OCD_DLY_100 && $stable(delay_strap))
    |-> $past(run_r) == 4'h9)
    else $error("long alert without ten windows");
  a_hold_alert: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    (!alert_n_oe_n && enable && win_last && over_now) |=> !alert_n_oe_n)
    else $error("alert dropped while over");
  a_release: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    (!alert_n_oe_n && enable && win_last && !over_now) |=> alert_n_oe_n)
    else $error("alert not released");
  a_margin_wide: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    (hysteresis_select_strap == `OCD_STRAP_VS) |=>
    release_margin_uv == `OCD_HYS_8MV)
    else $error("wide margin not selected");
  a_noise_short: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    (dly == OCD_DLY_10) |=> noise_offset_correction == `OCD_NOISE_UV)
    else $error("noise correction missing on short setting");
  c_short_trip: cover property (@(posedge clk_sys) disable iff (!nrst)
    dly == OCD_DLY_10 && $fell(alert_n_oe_n));
  c_med_trip: cover property (@(posedge clk_sys) disable iff (!nrst)
    dly == OCD_DLY_50 && $fell(alert_n_oe_n));
  c_long_trip: cover property (@(posedge clk_sys) disable iff (!nrst)
    dly == OCD_DLY_100 && $fell(alert_n_oe_n));
  c_release: cover property (@(posedge clk_sys) disable iff (!nrst)
    $rose(alert_n_oe_n));
  c_hold_over: cover property (@(posedge clk_sys) disable iff (!nrst)
    window_end && over_verdict && !alert_n_oe_n && $stable(alert_n_oe_n));
endmodule
`default_nettype wire

// >>> bench/ocd_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module ocd_host_model (
  // open-drain pin from the device
  input wire logic alert_n_o,
  input wire logic alert_n_oe_n,
  // resolved line seen by the controller
  output logic alert_line
);
  // pull-up wins whenever the device lets go
  assign alert_line = alert_n_oe_n ? 1'b1 : alert_n_o;
endmodule
`default_nettype wire

// >>> bench/ocd_core_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module ocd_core_tb_top;
  import ocd_pkg::*;
  logic clk_sys, nrst, enable, window_end, over_verdict;
  logic alert_n_o, alert_n_oe_n, alert_line;
  logic [1:0] delay_strap, hysteresis_select_strap;
  logic [15:0] sense_uv, limit_uv, noise_offset_correction, release_margin_uv;
  logic [15:0] marg [3] = '{16'h07D0, 16'h0FA0, 16'h1F40};
  int runs [3] = '{1, 5, 10};
  int bad_count, comparisons;
  int we_gap;
  ocd_core u_ocd_core (.clk_sys(clk_sys), .nrst(nrst), .enable(enable),
    .delay_strap(delay_strap),
    .hysteresis_select_strap(hysteresis_select_strap),
    .sense_uv(sense_uv), .limit_uv(limit_uv),
    .noise_offset_correction(noise_offset_correction),
    .release_margin_uv(release_margin_uv), .window_end(window_end),
    .over_verdict(over_verdict), .alert_n_o(alert_n_o),
    .alert_n_oe_n(alert_n_oe_n));
  ocd_host_model u_ocd_host_model (.alert_n_o(alert_n_o),
    .alert_n_oe_n(alert_n_oe_n), .alert_line(alert_line));
  // free-running system clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // verdict and end of run
  task report_and_stop;
    $display("mismatches %0d of %0d checks", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // compare seen against expected
  task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // step to just after the next rising edge
  task tick;
    @(posedge clk_sys);
    #5;
  endtask
  // bounded wait for the next window end pulse
  task wait_we;
    int k;
    k = 0;
    tick();
    while (window_end !== 1'b1 && k < 250) begin
      tick();
      k++;
    end
    we_gap = k;
    if (window_end !== 1'b1) begin
      bad_count++;
      report_and_stop();
    end
  endtask
  // n-1 over-limit windows must leave the line high
  task run_short_of(input int n);
    for (int w = 1; w < n; w++) begin
      wait_we();
      chk("alert before count", 16'(alert_line), 16'h0001);
    end
  endtask
  // main sequence over all three strap settings
  initial begin
    nrst = 1'b0;
    enable = 1'b0;
    delay_strap = 2'h0;
    hysteresis_select_strap = 2'h0;
    sense_uv = 16'h0000;
    limit_uv = 16'h2710;
    bad_count = 0;
    comparisons = 0;
    repeat (5) @(posedge clk_sys);
    #5 nrst = 1'b1;
    chk("alert after reset", 16'(alert_line), 16'h0001);
    for (int i = 0; i < 3; i++) begin
      delay_strap = 2'(i);
      hysteresis_select_strap = 2'(i);
      enable = 1'b0;
      tick();
      tick();
      chk("alert disabled", 16'(alert_line), 16'h0001);
      chk("margin", release_margin_uv, marg[i]);
      chk("noise", noise_offset_correction,
        i == 0 ? 16'h01F4 : 16'h0000);
      enable = 1'b1;
      sense_uv = 16'h0000;
      wait_we();
      sense_uv = 16'h3A98;
      run_short_of(runs[i]);
      sense_uv = 16'h0000;
      wait_we();
      chk("alert in range", 16'(alert_line), 16'h0001);
      chk("verdict in range", 16'(over_verdict), 16'h0000);
      sense_uv = 16'h3A98;
      run_short_of(runs[i]);
      wait_we();
      chk("alert trip", 16'(alert_line), 16'h0000);
      chk("verdict", 16'(over_verdict), 16'h0001);
      wait_we();
      chk("alert hold", 16'(alert_line), 16'h0000);
      // 200 cycles a window: 199 ticks after the first one
      chk("window period", 16'(we_gap), 16'h00C7);
      if (i != 1) begin
        sense_uv = 16'h0000;
        wait_we();
        chk("alert release", 16'(alert_line), 16'h0001);
      end
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
